// File: rtl/bbp_pkg.sv
package bbp_pkg;
  localparam int WORD_W = 16;
  localparam int IDX_W = 8;
  localparam int IN_WORDS = 250;
  localparam int OUT_WORDS = 248;
  localparam int BLK_DATA = 200;
  localparam int DB_SIZE = 5000;
  localparam int PERR_WORDS = 14;
  localparam int XFER_WORDS = 6;
  localparam int EIDX_WORDS = 4;
  localparam logic [7:0] RD_REQ = 8'h01;
  localparam logic [7:0] RD_DATA = 8'h02;
  localparam logic [7:0] RD_SCAN = 8'hCA;
  localparam logic [7:0] RD_IDENT = 8'hCB;
  localparam logic [7:0] RD_PERR = 8'hD3;
  localparam logic [7:0] RD_XFER = 8'hE1;
  localparam logic [7:0] RD_EIDX = 8'hE7;
  localparam logic [7:0] RD_SPARE = 8'hEB;
  localparam logic [7:0] RD_ID = 8'hF9;
  localparam logic [7:0] WR_DATA = 8'h01;
  localparam logic [7:0] WR_DATA_END = 8'hC8;
  localparam logic [7:0] WR_LAST = 8'hF7;
  localparam logic [7:0] CE_MOD = 8'h02;
  localparam logic [7:0] CE_P1 = 8'h03;
  localparam logic [7:0] CE_P2 = 8'h04;
  localparam logic [7:0] CFG_RDN = 8'h01;
  localparam logic [7:0] CFG_WRN = 8'h02;
  localparam logic [7:0] CFG_P1_EN = 8'h07;
  localparam logic [7:0] CFG_P2_EN = 8'h15;
  localparam logic [15:0] CFG_BLK = 16'h2328;
  localparam logic [15:0] CMD_P1_BLK = 16'h1770;
  localparam logic [15:0] CMD_P2_BLK = 16'h17D4;
  localparam logic [2:0] CMD_LAST = 3'h7;
  localparam int CMD_PER_BLK = 25;
  typedef enum logic [1:0] {ST_SEND = 2'b01, ST_WAIT = 2'b10} bbp_st_t;
  typedef enum logic [2:0] {PH_CFG = 3'b001, PH_CMD = 3'b010, PH_RUN = 3'b100} bbp_ph_t;
endpackage : bbp_pkg

// File: rtl/bbp_link_if.sv
`timescale 1ns/1ns
interface bbp_link_if;
  logic rd_valid;
  logic [7:0] rd_idx;
  logic [15:0] rd_data;
  logic wr_valid;
  logic [7:0] wr_idx;
  logic [15:0] wr_data;
  modport dev (output rd_valid, rd_idx, rd_data, input wr_valid, wr_idx, wr_data);
  modport host (input rd_valid, rd_idx, rd_data, output wr_valid, wr_idx, wr_data);
endinterface : bbp_link_if

// File: rtl/bbp_host.sv
`timescale 1ns/1ns
module bbp_host import bbp_pkg::*; (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  bbp_link_if.host lnk,
  output logic [15:0] o_src_blk,
  output logic [7:0] o_src_idx,
  input wire logic [15:0] i_src_data,
  output logic o_up_valid,
  output logic [15:0] o_up_blk,
  output logic [7:0] o_up_idx,
  output logic [15:0] o_up_data
);
  logic [15:0] img [IN_WORDS];
  bbp_st_t st_reg;
  logic [7:0] cnt_reg;
  logic [15:0] req_reg;
  logic [7:0] src_idx_reg;
  logic wr_valid_reg;
  logic [7:0] wr_idx_reg;
  logic [15:0] wr_data_reg;
  logic up_act_reg;
  logic [7:0] up_cnt_reg;
  logic up_valid_reg;
  logic [15:0] up_blk_reg;
  logic [7:0] up_idx_reg;
  logic [15:0] up_data_reg;

  wire logic blk_end = lnk.rd_valid && lnk.rd_idx == RD_ID;
  wire logic sending = st_reg == ST_SEND;
  wire logic in_data = cnt_reg >= WR_DATA && cnt_reg <= WR_DATA_END;
  // Word 0 carries the answered id; data words come from the user source
  wire logic [15:0] wr_word = (cnt_reg == 8'h00) ? req_reg : in_data ? i_src_data : 16'h0000; // [R6] [R9]
  wire logic [7:0] up_word = up_cnt_reg + RD_DATA;

  always_ff @(posedge i_ref_clk) begin
    if (lnk.rd_valid) begin
      img[lnk.rd_idx] <= lnk.rd_data;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_reg <= ST_WAIT;
      cnt_reg <= 8'h00;
      req_reg <= 16'h0000;
      src_idx_reg <= 8'h00;
      wr_valid_reg <= 1'b0;
      wr_idx_reg <= 8'h00;
      wr_data_reg <= 16'h0000;
    end else begin
      wr_valid_reg <= sending;
      wr_idx_reg <= cnt_reg;
      wr_data_reg <= wr_word;
      src_idx_reg <= cnt_reg;
      if (blk_end) begin
        st_reg <= ST_SEND; // [R18]
        cnt_reg <= 8'h00;
        req_reg <= img[RD_REQ]; // [R6]
      end else if (sending) begin
        cnt_reg <= cnt_reg + 8'h01;
        if (cnt_reg == WR_LAST) begin
          st_reg <= ST_WAIT;
        end
      end
    end
  end

  // Read data is unloaded under the block's own id, which only arrives last
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      up_act_reg <= 1'b0;
      up_cnt_reg <= 8'h00;
      up_valid_reg <= 1'b0;
      up_blk_reg <= 16'h0000;
      up_idx_reg <= 8'h00;
      up_data_reg <= 16'h0000;
    end else begin
      up_valid_reg <= up_act_reg;
      up_idx_reg <= up_cnt_reg;
      up_data_reg <= img[up_word];
      if (blk_end) begin
        up_act_reg <= 1'b1;
        up_cnt_reg <= 8'h00;
        up_blk_reg <= lnk.rd_data; // [R5]
      end else if (up_act_reg) begin
        up_cnt_reg <= up_cnt_reg + 8'h01;
        if (up_cnt_reg == 8'(BLK_DATA - 1)) begin
          up_act_reg <= 1'b0;
        end
      end
    end
  end

  assign lnk.wr_valid = wr_valid_reg;
  assign lnk.wr_idx = wr_idx_reg;
  assign lnk.wr_data = wr_data_reg;
  assign o_src_blk = req_reg;
  assign o_src_idx = src_idx_reg;
  assign o_up_valid = up_valid_reg;
  assign o_up_blk = up_blk_reg;
  assign o_up_idx = up_idx_reg;
  assign o_up_data = up_data_reg;
endmodule : bbp_host

// File: rtl/bbp_dev.sv
// Design decisions made here: the placing of the registers and the strobed register port.
`timescale 1ns/1ns
// How it works
// R1 - Database words 0..4999 paged in and out
// R2 - Read block: reserved, write request, 200 data
// R3 - Status: scan counter and identity words
// R4 - Port error, transfer status, error index words
// R5 - Read block id in word 249
// R6 - Host answers requested write block id
// R7 - Read and write blocks cycle independently
// R8 - Other id or break request interrupts sequence
// R9 - Host write block: id, 200 data, spare
// R10 - Write block id selects database location
// R11 - Restart requests configuration blocks one by one
// R12 - Host general configuration block tagged 9000
// R13 - Config request block carries three error words
// R14 - Faulty configuration sets error bits
// R15 - No normal operation while errors remain
// R16 - Command lists via blocks 6000-6003, 6100-6103
// R17 - Hundred commands, 25 eight-word definitions per block
// R18 - Host serves every command-list request in order
// R19 - Input image 250, output image 248 words
// R20 - Spare and reserved words read zero
module bbp_dev import bbp_pkg::*; #(
  parameter int DB_WORDS = DB_SIZE,
  parameter logic [127:0] IDENT = 128'h0001_0000_0001_0000_0001_0000_0001_0000 // Arbitrary
) (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  bbp_link_if.dev lnk,
  input wire logic [$clog2(DB_WORDS)-1:0] i_db_addr,
  input wire logic i_db_we,
  input wire logic [15:0] i_db_wdata,
  output logic [15:0] o_db_rdata,
  input wire logic i_brk_req,
  input wire logic [15:0] i_brk_blk,
  input wire logic [PERR_WORDS*16-1:0] i_port_err,
  input wire logic [EIDX_WORDS*16-1:0] i_err_idx,
  output logic o_cfg_ok,
  output logic o_cmd_valid,
  output logic o_cmd_port,
  output logic [6:0] o_cmd_idx,
  output logic [2:0] o_cmd_word,
  output logic [15:0] o_cmd_data
);
  localparam int DB_AW = $clog2(DB_WORDS);
  localparam int MAX_BLK = DB_WORDS / BLK_DATA;

  logic [15:0] db [DB_WORDS];
  bbp_st_t st_reg;
  bbp_ph_t ph_reg;
  logic [7:0] cnt_reg;
  logic [15:0] req_reg;
  logic [15:0] cur_id_reg;
  logic [4:0] rd_seq_reg;
  logic [4:0] wr_seq_reg;
  logic [15:0] rd_cnt_reg;
  logic [15:0] wr_cnt_reg;
  logic [15:0] p1_en_reg;
  logic [15:0] p2_en_reg;
  logic [15:0] mod_err_reg;
  logic [15:0] p1_err_reg;
  logic [15:0] p2_err_reg;
  logic [2:0] cmd_blk_reg;
  logic brk_pend_reg;
  logic brk_act_reg;
  logic [15:0] brk_blk_reg;
  logic [15:0] scan_reg;
  logic [15:0] rdx_reg;
  logic [15:0] wrx_reg;
  logic [15:0] bad_reg;
  logic rd_valid_reg;
  logic [7:0] rd_idx_reg;
  logic [15:0] rd_data_reg;
  logic [15:0] db_rdata_reg;
  logic cmd_valid_reg;
  logic cmd_port_reg;
  logic [6:0] cmd_idx_reg;
  logic [2:0] cmd_word_reg;
  logic [15:0] cmd_data_reg;

  wire logic run = ph_reg == PH_RUN;
  wire logic wv = lnk.wr_valid && st_reg == ST_WAIT;
  wire logic fin = wv && lnk.wr_idx == WR_LAST;
  wire logic send_end = st_reg == ST_SEND && cnt_reg == RD_ID;
  wire logic id_ok = cur_id_reg == req_reg;
  wire logic w_data = lnk.wr_idx >= WR_DATA && lnk.wr_idx <= WR_DATA_END;
  wire logic [7:0] w_off = lnk.wr_idx - WR_DATA;
  wire logic id_in_db = cur_id_reg < 16'(MAX_BLK);
  wire logic [DB_AW-1:0] wa = DB_AW'(cur_id_reg * BLK_DATA + 32'(w_off));
  wire logic db_wr = wv && w_data && run && id_in_db; // [R1] [R10]
  wire logic cmd_wr = wv && w_data && ph_reg == PH_CMD && id_ok; // [R17]
  wire logic [6:0] cmd_idx = 7'(cmd_blk_reg[1:0] * CMD_PER_BLK + 32'(w_off[7:3]));
  wire logic is_cfg = cur_id_reg == CFG_BLK;

  // A zero or oversized block count cannot map into the database
  wire logic rdn_bad = rd_cnt_reg == 16'h0000 || rd_cnt_reg > 16'(MAX_BLK);
  wire logic wrn_bad = wr_cnt_reg == 16'h0000 || wr_cnt_reg > 16'(MAX_BLK);
  wire logic [15:0] mod_err_w = {14'h0000, wrn_bad, rdn_bad}; // [R14]
  wire logic [15:0] p1_err_w = {15'h0000, p1_en_reg > 16'h0001}; // [R14]
  wire logic [15:0] p2_err_w = {15'h0000, p2_en_reg > 16'h0001}; // [R14]
  wire logic cfg_bad = |{mod_err_w, p1_err_w, p2_err_w};

  wire logic rd_wrap = 16'({11'h000, rd_seq_reg} + 16'h0001) >= rd_cnt_reg;
  wire logic wr_wrap = 16'({11'h000, wr_seq_reg} + 16'h0001) >= wr_cnt_reg;
  wire logic [4:0] rd_nx = rd_wrap ? 5'h00 : rd_seq_reg + 5'h01;
  wire logic wr_adv = id_ok && !brk_act_reg; // [R8]
  wire logic [4:0] wr_nx = !wr_adv ? wr_seq_reg : wr_wrap ? 5'h00 : wr_seq_reg + 5'h01;
  wire logic [2:0] cmd_nx = cmd_blk_reg + 3'h1;
  wire logic [15:0] cmd_id_nx = (cmd_nx[2] ? CMD_P2_BLK : CMD_P1_BLK) + {14'h0000, cmd_nx[1:0]};
  wire logic brk_take = fin && run && brk_pend_reg;

  wire logic in_rd = cnt_reg >= RD_DATA && cnt_reg < RD_SCAN;
  wire logic in_ident = cnt_reg >= RD_IDENT && cnt_reg < RD_PERR;
  wire logic in_perr = cnt_reg >= RD_PERR && cnt_reg < RD_XFER;
  wire logic in_xfer = cnt_reg >= RD_XFER && cnt_reg < RD_EIDX;
  wire logic in_eidx = cnt_reg >= RD_EIDX && cnt_reg < RD_SPARE;
  wire logic [7:0] o_ident = cnt_reg - RD_IDENT;
  wire logic [7:0] o_perr = cnt_reg - RD_PERR;
  wire logic [7:0] o_xfer = cnt_reg - RD_XFER;
  wire logic [7:0] o_eidx = cnt_reg - RD_EIDX;
  wire logic [XFER_WORDS*16-1:0] xfer = {48'h0, bad_reg, wrx_reg, rdx_reg};
  wire logic [DB_AW-1:0] ra = DB_AW'(rd_seq_reg * BLK_DATA + 32'(cnt_reg - RD_DATA));
  wire logic [15:0] cfg_word = (cnt_reg == CE_MOD) ? mod_err_reg :
    (cnt_reg == CE_P1) ? p1_err_reg : (cnt_reg == CE_P2) ? p2_err_reg : 16'h0000; // [R13]
  wire logic [15:0] run_word = in_rd ? db[ra] : // [R2]
    (cnt_reg == RD_SCAN) ? scan_reg : // [R3]
    in_ident ? IDENT[{o_ident[2:0], 4'h0} +: 16] : // [R3]
    in_perr ? i_port_err[{o_perr[3:0], 4'h0} +: 16] : // [R4]
    in_xfer ? xfer[{o_xfer[2:0], 4'h0} +: 16] : // [R4]
    in_eidx ? i_err_idx[{o_eidx[1:0], 4'h0} +: 16] : // [R4]
    (cnt_reg == RD_ID) ? {11'h000, rd_seq_reg} : 16'h0000; // [R5] [R20]
  wire logic [15:0] rd_word = (cnt_reg == RD_REQ) ? req_reg : // [R2] [R11]
    (ph_reg == PH_CFG) ? cfg_word : run ? run_word : 16'h0000; // [R20]

  always_ff @(posedge i_ref_clk) begin
    if (db_wr) begin
      db[wa] <= lnk.wr_data;
    end
    // The user port writes last so it wins a same-address collision
    if (i_db_we) begin
      db[i_db_addr] <= i_db_wdata;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rd_valid_reg <= 1'b0;
      rd_idx_reg <= 8'h00;
      rd_data_reg <= 16'h0000;
      db_rdata_reg <= 16'h0000;
      cmd_valid_reg <= 1'b0;
      cmd_port_reg <= 1'b0;
      cmd_idx_reg <= 7'h00;
      cmd_word_reg <= 3'h0;
      cmd_data_reg <= 16'h0000;
    end else begin
      rd_valid_reg <= st_reg == ST_SEND; // [R19]
      rd_idx_reg <= cnt_reg;
      rd_data_reg <= rd_word;
      db_rdata_reg <= db[i_db_addr];
      cmd_valid_reg <= cmd_wr; // [R17]
      cmd_port_reg <= cmd_blk_reg[2];
      cmd_idx_reg <= cmd_idx;
      cmd_word_reg <= w_off[2:0];
      cmd_data_reg <= lnk.wr_data;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cur_id_reg <= 16'h0000;
      rd_cnt_reg <= 16'h0000;
      wr_cnt_reg <= 16'h0000;
      p1_en_reg <= 16'h0000;
      p2_en_reg <= 16'h0000;
      brk_pend_reg <= 1'b0;
      brk_blk_reg <= 16'h0000;
      scan_reg <= 16'h0000;
      rdx_reg <= 16'h0000;
      wrx_reg <= 16'h0000;
      bad_reg <= 16'h0000;
    end else begin
      if (wv && lnk.wr_idx == 8'h00) begin
        cur_id_reg <= lnk.wr_data;
      end
      if (wv && ph_reg == PH_CFG && is_cfg) begin // [R12]
        if (lnk.wr_idx == CFG_RDN) rd_cnt_reg <= lnk.wr_data;
        if (lnk.wr_idx == CFG_WRN) wr_cnt_reg <= lnk.wr_data;
        if (lnk.wr_idx == CFG_P1_EN) p1_en_reg <= lnk.wr_data;
        if (lnk.wr_idx == CFG_P2_EN) p2_en_reg <= lnk.wr_data;
      end
      brk_pend_reg <= i_brk_req | (brk_pend_reg & ~brk_take); // [R8]
      if (i_brk_req) brk_blk_reg <= i_brk_blk;
      if (fin) scan_reg <= scan_reg + 16'h0001;
      if (send_end) rdx_reg <= rdx_reg + 16'h0001;
      if (fin) wrx_reg <= wrx_reg + 16'h0001;
      if (fin && run && !id_in_db) bad_reg <= bad_reg + 16'h0001;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_reg <= ST_SEND;
      ph_reg <= PH_CFG;
      cnt_reg <= 8'h00;
      req_reg <= CFG_BLK;
      rd_seq_reg <= 5'h00;
      wr_seq_reg <= 5'h00;
      mod_err_reg <= 16'h0000;
      p1_err_reg <= 16'h0000;
      p2_err_reg <= 16'h0000;
      cmd_blk_reg <= 3'h0;
      brk_act_reg <= 1'b0;
    end else if (send_end) begin
      st_reg <= ST_WAIT;
      cnt_reg <= 8'h00;
    end else if (st_reg == ST_SEND) begin
      cnt_reg <= cnt_reg + 8'h01;
    end else if (fin) begin
      st_reg <= ST_SEND;
      case (ph_reg)
        PH_CFG: begin
          if (is_cfg) begin
            mod_err_reg <= mod_err_w; // [R13] [R14]
            p1_err_reg <= p1_err_w;
            p2_err_reg <= p2_err_w;
          end
          if (is_cfg && !cfg_bad) begin // [R15]
            ph_reg <= PH_CMD;
            req_reg <= CMD_P1_BLK; // [R16]
            cmd_blk_reg <= 3'h0;
          end
        end
        PH_CMD: begin
          // A wrong answer repeats the same request so no list block is skipped
          if (id_ok && cmd_blk_reg == CMD_LAST) begin
            ph_reg <= PH_RUN;
            req_reg <= 16'h0000;
          end else if (id_ok) begin
            cmd_blk_reg <= cmd_nx;
            req_reg <= cmd_id_nx; // [R16]
          end
        end
        PH_RUN: begin
          rd_seq_reg <= rd_nx; // [R7]
          wr_seq_reg <= wr_nx; // [R7]
          brk_act_reg <= brk_pend_reg;
          req_reg <= brk_pend_reg ? brk_blk_reg : {11'h000, wr_nx}; // [R8]
        end
        default: begin
          ph_reg <= PH_CFG;
          req_reg <= CFG_BLK;
        end
      endcase
    end
  end

  assign lnk.rd_valid = rd_valid_reg;
  assign lnk.rd_idx = rd_idx_reg;
  assign lnk.rd_data = rd_data_reg;
  assign o_db_rdata = db_rdata_reg;
  assign o_cfg_ok = ph_reg[2];
  assign o_cmd_valid = cmd_valid_reg;
  assign o_cmd_port = cmd_port_reg;
  assign o_cmd_idx = cmd_idx_reg;
  assign o_cmd_word = cmd_word_reg;
  assign o_cmd_data = cmd_data_reg;
endmodule : bbp_dev

// File: tb/bbp_link_assertions.sv
`timescale 1ns/1ns
module bbp_link_assertions import bbp_pkg::*; (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic rd_valid,
  input wire logic [7:0] rd_idx,
  input wire logic [15:0] rd_data,
  input wire logic wr_valid,
  input wire logic [7:0] wr_idx,
  input wire logic [15:0] wr_data
);
  logic [15:0] req_reg;
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_arst_n);
  // Last requested id, so the answer can be matched without a model
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      req_reg <= 16'h0000;
    end else if (rd_valid && rd_idx == 8'h01) begin
      req_reg <= rd_data;
    end
  end
  chk_rd_first_word: assert property ($rose(rd_valid) |-> rd_idx == 8'h00)
    else $error("read block does not open at word zero");
  chk_rd_word_step: assert property (rd_valid && rd_idx != RD_ID |=>
    rd_valid && rd_idx == $past(rd_idx) + 8'h01) else $error("read word order broken");
  chk_rd_block_end: assert property (rd_valid && rd_idx == RD_ID |=> !rd_valid)
    else $error("read block longer than its image");
  chk_wr_word_step: assert property (wr_valid && wr_idx != WR_LAST |=>
    wr_valid && wr_idx == $past(wr_idx) + 8'h01) else $error("write word order broken");
  chk_answer_time: assert property (rd_valid && rd_idx == RD_ID |->
    ##2 wr_valid && wr_idx == 8'h00) else $error("write block not started in time");
  chk_answer_id: assert property (wr_valid && wr_idx == 8'h00 |-> wr_data == req_reg)
    else $error("answered id differs from request");
  chk_next_read: assert property (wr_valid && wr_idx == WR_LAST |->
    ##2 rd_valid && rd_idx == 8'h00) else $error("next read block not started in time");
  chk_rd_zero_words: assert property (rd_valid &&
    (rd_idx == 8'h00 || (rd_idx >= RD_SPARE && rd_idx < RD_ID)) |-> rd_data == 16'h0000)
    else $error("reserved read word not zero");
  chk_wr_spare_zero: assert property (wr_valid && wr_idx > WR_DATA_END |->
    wr_data == 16'h0000) else $error("spare write word not zero");
  cover property (rd_valid && rd_idx == 8'h01 && rd_data == CFG_BLK);
  cover property (wr_valid && wr_idx == 8'h00 && wr_data == CMD_P2_BLK + 16'h0003);
  cover property (rd_valid && rd_idx == RD_ID && rd_data == 16'h0002);
endmodule : bbp_link_assertions

// File: tb/backplane_block_pager_bench.sv
`timescale 1ns/1ns
module backplane_block_pager_bench import bbp_pkg::*;;
  logic ref_clk;
  logic arst_n;
  logic [9:0] db_addr;
  logic db_we;
  logic [15:0] db_wdata;
  logic [15:0] db_rdata;
  logic brk_req;
  logic [15:0] brk_blk;
  logic [PERR_WORDS*16-1:0] port_err;
  logic [EIDX_WORDS*16-1:0] err_idx;
  logic cfg_ok;
  logic cmd_valid;
  logic cmd_port;
  logic [6:0] cmd_idx;
  logic [2:0] cmd_word;
  logic [15:0] cmd_data;
  logic [15:0] src_blk;
  logic [7:0] src_idx;
  logic [15:0] src_data;
  logic up_valid;
  logic [15:0] up_blk;
  logic [7:0] up_idx;
  logic [15:0] up_data;
  logic [15:0] img [0:249];
  logic [15:0] scan_prev;
  logic [15:0] rd_val;
  int blk_cnt = 0;
  int cmd_seen = 0;
  int num_errors = 0;
  int cmp_count = 0;

  bbp_link_if bbp_link_if_inst ();
  bbp_dev #(.DB_WORDS(1000)) bbp_dev_inst (.i_ref_clk(ref_clk), .i_arst_n(arst_n),
    .lnk(bbp_link_if_inst), .i_db_addr(db_addr), .i_db_we(db_we), .i_db_wdata(db_wdata),
    .o_db_rdata(db_rdata), .i_brk_req(brk_req), .i_brk_blk(brk_blk), .i_port_err(port_err),
    .i_err_idx(err_idx), .o_cfg_ok(cfg_ok), .o_cmd_valid(cmd_valid), .o_cmd_port(cmd_port),
    .o_cmd_idx(cmd_idx), .o_cmd_word(cmd_word), .o_cmd_data(cmd_data));
  bbp_host bbp_host_inst (.i_ref_clk(ref_clk), .i_arst_n(arst_n), .lnk(bbp_link_if_inst),
    .o_src_blk(src_blk), .o_src_idx(src_idx), .i_src_data(src_data), .o_up_valid(up_valid),
    .o_up_blk(up_blk), .o_up_idx(up_idx), .o_up_data(up_data));
  bbp_link_assertions bbp_link_assertions_inst (.i_ref_clk(ref_clk), .i_arst_n(arst_n),
    .rd_valid(bbp_link_if_inst.rd_valid), .rd_idx(bbp_link_if_inst.rd_idx),
    .rd_data(bbp_link_if_inst.rd_data), .wr_valid(bbp_link_if_inst.wr_valid),
    .wr_idx(bbp_link_if_inst.wr_idx), .wr_data(bbp_link_if_inst.wr_data));

  // First general block carries a zero read count so the refusal path is exercised
  function automatic logic [15:0] src_word(logic [15:0] b, logic [7:0] i, int n);
    if (b != CFG_BLK) return {b[7:0], i};
    if (i == 8'h00) return (n < 2) ? 16'h0000 : 16'h0003;
    if (i == 8'h01) return 16'h0002;
    return (i == 8'h06 || i == 8'h14) ? 16'h0001 : 16'h0000;
  endfunction : src_word

  assign src_data = src_word(src_blk, src_idx, blk_cnt);

  always #2 ref_clk = ~ref_clk;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  always @(posedge ref_clk) begin
    if (bbp_link_if_inst.rd_valid === 1'b1) begin
      img[bbp_link_if_inst.rd_idx] <= bbp_link_if_inst.rd_data;
      if (bbp_link_if_inst.rd_idx == RD_ID) blk_cnt <= blk_cnt + 1;
    end
    if (cmd_valid === 1'b1) begin
      cmd_seen <= cmd_seen + 1;
      check(cmd_data, {(cmd_port ? CMD_P2_BLK[7:0] : CMD_P1_BLK[7:0]) + 8'(cmd_idx / 25),
        8'(cmd_idx % 25) * 8'h08 + 8'(cmd_word)});
    end
    // The host unloads the block it last saw, filed under that block's own id
    if (up_valid === 1'b1) begin
      check(up_blk, img[249]);
      check(up_data, img[up_idx + 8'h02]);
    end
  end

  task automatic wait_blk();
    int n;
    n = blk_cnt;
    for (int i = 0; i < 2000 && blk_cnt == n; i++) @(negedge ref_clk);
  endtask : wait_blk

  task automatic db_write(input logic [9:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    db_addr <= a;
    db_wdata <= d;
    db_we <= 1'b1;
    @(posedge ref_clk);
    db_we <= 1'b0;
  endtask : db_write

  task automatic db_read(input logic [9:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    db_addr <= a;
    @(posedge ref_clk);
    @(negedge ref_clk);
    d = db_rdata;
  endtask : db_read

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test

  initial begin
    ref_clk = 1'b0;
    arst_n = 1'b0;
    db_addr = 10'h000;
    db_we = 1'b0;
    db_wdata = 16'h0000;
    brk_req = 1'b0;
    brk_blk = 16'h0000;
    err_idx = {16'hC003, 16'hC002, 16'hC001, 16'hC000};
    for (int j = 0; j < PERR_WORDS; j++) port_err[16*j +: 16] = 16'hE000 + 16'(j);
    repeat (8) @(posedge ref_clk);
    arst_n <= 1'b1;
    db_write(10'h190, 16'h4A4A);
    db_write(10'h257, 16'h5B5B);
    wait_blk();
    check(img[1], CFG_BLK);
    check(img[2], 16'h0000);
    wait_blk();
    check(img[1], CFG_BLK);
    check(img[2], 16'h0001);
    check({15'h0000, cfg_ok}, 16'h0000);
    for (int k = 0; k < 8; k++) begin
      wait_blk();
      check(img[1], (k < 4) ? CMD_P1_BLK + 16'(k) : CMD_P2_BLK + 16'(k - 4));
      check(img[249], 16'h0000);
    end
    wait_blk();
    check({15'h0000, cfg_ok}, 16'h0001);
    check(img[249], 16'h0000);
    check(img[1], 16'h0000);
    check(img[211], 16'hE000);
    check(img[224], 16'hE00D);
    check(img[231], 16'hC000);
    check(img[234], 16'hC003);
    scan_prev = img[202];
    for (int n = 1; n < 6; n++) begin
      wait_blk();
      check(img[249], 16'(n % 3));
      check(img[1], 16'(n % 2));
      check(img[202], scan_prev + 16'h0001);
      scan_prev = img[202];
      if (n == 2) check(img[2], 16'h4A4A);
      if (n == 3) check(img[201], 16'h00C7);
      if (n == 4) check(img[3], 16'h0101);
      if (n == 5) check(img[201], 16'h5B5B);
    end
    @(posedge ref_clk);
    brk_blk <= 16'h0004;
    brk_req <= 1'b1;
    @(posedge ref_clk);
    brk_req <= 1'b0;
    wait_blk();
    check(img[1], 16'h0004);
    wait_blk();
    check(img[1], 16'h0000);
    db_read(10'h320, rd_val);
    check(rd_val, 16'h0400);
    check(16'(cmd_seen), 16'h0640);
    // An id past the database end is refused and counted in the status area
    @(posedge ref_clk);
    brk_blk <= 16'h0005;
    brk_req <= 1'b1;
    @(posedge ref_clk);
    brk_req <= 1'b0;
    wait_blk();
    check(img[1], 16'h0005);
    wait_blk();
    check(img[227], 16'h0001);
    check(img[1], 16'h0001);
    stop_test();
  end

  // Whole run is about twenty exchanges of roughly 500 cycles each
  initial begin
    repeat (40000) @(posedge ref_clk);
    num_errors++;
    $display("ERROR %0t: watchdog expired", $time);
    stop_test();
  end
endmodule : backplane_block_pager_bench
